// [pkg/txm_pkg.sv]
// Package for the transmit modulator configuration bank: register offsets,
// field positions, reset values, derived-word widths and completion states.
// Assumes an 8-bit register access path with 6-bit addresses.
package txm_pkg;

   // Register offsets
   localparam logic [5:0] TXM_ADDR_MOD_UPPER  = 6'h13;
   localparam logic [5:0] TXM_ADDR_SPC_MANT   = 6'h14;
   localparam logic [5:0] TXM_ADDR_DEVIATION  = 6'h15;
   localparam logic [5:0] TXM_ADDR_STATE_CFG  = 6'h17;

   // Reset values
   localparam logic [7:0] TXM_RST_MOD_UPPER   = 8'h22;
   localparam logic [7:0] TXM_RST_SPC_MANT    = 8'hF8;
   localparam logic [7:0] TXM_RST_DEVIATION   = 8'h47;
   localparam logic [7:0] TXM_RST_STATE_CFG   = 8'h00;

   // Writable-bit masks; every other bit reads as zero
   localparam logic [7:0] TXM_MASK_MOD_UPPER  = 8'hF3;
   localparam logic [7:0] TXM_MASK_SPC_MANT   = 8'hFF;
   localparam logic [7:0] TXM_MASK_DEVIATION  = 8'h77;
   localparam logic [7:0] TXM_MASK_STATE_CFG  = 8'h03;
   localparam logic [7:0] TXM_READ_ZERO       = 8'h00;

   // Field positions
   localparam int TXM_FEC_BIT      = 7;
   localparam int TXM_PRE_LSB      = 4;
   localparam int TXM_SPC_E_LSB    = 0;
   localparam int TXM_DEV_E_LSB    = 4;
   localparam int TXM_DEV_M_LSB    = 0;
   localparam int TXM_TXOFF_LSB    = 0;

   // Implicit leading ones of the mantissas
   localparam logic [8:0] TXM_SPC_IMPLICIT = 9'h100;
   localparam logic [3:0] TXM_DEV_IMPLICIT = 4'h8;

   // Derived word widths
   localparam int TXM_SPC_W  = 12;
   localparam int TXM_DEV_W  = 11;

   // Minimum preamble byte counts per code
   localparam logic [4:0] TXM_PRE_BYTES_0 = 5'h02;
   localparam logic [4:0] TXM_PRE_BYTES_1 = 5'h03;
   localparam logic [4:0] TXM_PRE_BYTES_2 = 5'h04;
   localparam logic [4:0] TXM_PRE_BYTES_3 = 5'h06;
   localparam logic [4:0] TXM_PRE_BYTES_4 = 5'h08;
   localparam logic [4:0] TXM_PRE_BYTES_5 = 5'h0C;
   localparam logic [4:0] TXM_PRE_BYTES_6 = 5'h10;
   localparam logic [4:0] TXM_PRE_BYTES_7 = 5'h18;

   // Radio state requested after a packet has gone out
   typedef enum logic [1:0] {
      TXM_ST_IDLE     = 2'b00,
      TXM_ST_SYNTH_ON = 2'b01,
      TXM_ST_TX       = 2'b10,
      TXM_ST_RX_UNUSED = 2'b11
   } txm_radio_state_t;

   // Decoded configuration carried as one group
   typedef struct packed {
      logic       error_correction_enable;
      logic [2:0] preamble_code;
      logic [1:0] spacing_exponent;
      logic [7:0] spacing_mantissa;
      logic [2:0] deviation_exponent;
      logic [2:0] deviation_mantissa;
      logic [1:0] tx_completion_state;
   } txm_cfg_t;

endpackage

// [design/txm_config.sv]
// Transmit modulator configuration bank with derived modulator words.
// Assumes register accesses arrive already synchronous to sys_clk_in, one
// byte per cycle, and that the radio controller pulses packet_done_in.
// Derived words follow the registers one cycle later; the carrier word follows the
// registered spacing word, so it settles two cycles after a spacing write.
// Base frequency arrives in the same units as the spacing word, so the carrier is a plain sum.
// The controller should switch msk_mode_in only between packets: the words follow it
// one cycle late, and a mid-packet change would briefly mix the two readings.
// Completion code 11 is left to the host to avoid; it falls back to idle here.
// Operation
// - Error correction enable bit 7 turns on coded, interleaved payload.
// - Preamble code bits 6:4 map to 2,3,4,6,8,12,16,24 bytes.
// - Bits 1:0 of upper modulator register hold the spacing exponent.
// - Spacing mantissa is bits 7:0 with an implicit leading one.
// - Spacing equals (256 + mantissa) shifted by exponent, unsigned.
// - Carrier word is base plus channel index times spacing.
// - FSK deviation mantissa is eight plus the stored three bits.
// - FSK deviation equals (8 + mantissa) shifted by exponent bits 6:4.
// - In MSK the mantissa gives the phase-change fraction of a symbol.
// - After a packet: 00 idle, 01 synth on, 10 restart preamble.
// - State config bits 7:2 are reserved without function.
`timescale 1ns/1ps
module txm_config
   import txm_pkg::*;
#(
   parameter int BASE_W = 26,                              // Base frequency word width
   parameter int CHANNEL_INDEX_W = 8                                // Channel index width
) (
   input  wire logic                    sys_clk_in,        // 50 MHz clock
   input  wire logic                    resetn_in,         // Async reset, low
   input  wire logic [5:0]              reg_addr_in,       // Register address
   input  wire logic                    reg_wr_in,         // Write strobe
   input  wire logic                    reg_rd_in,         // Read strobe
   input  wire logic [7:0]              reg_wdata_in,      // Write data
   output logic      [7:0]              reg_rdata_out,     // Read data, registered
   input  wire logic [BASE_W-1:0]       base_freq_in,      // Base, spacing units
   input  wire logic [CHANNEL_INDEX_W-1:0]       channel_index_in,  // Selected channel
   input  wire logic                    msk_mode_in,       // High when MSK active
   input  wire logic                    packet_done_in,    // Packet fully sent pulse
   output logic                         fec_enable_out,    // Payload coding on
   output logic      [4:0]              preamble_bytes_out,// Minimum preamble bytes
   output logic      [TXM_SPC_W-1:0]    spacing_word_out,  // Spacing, f/2^18 units
   output logic      [BASE_W:0]         carrier_word_out,  // Carrier, f/2^18 units
   output logic      [TXM_DEV_W-1:0]    deviation_word_out,// FSK deviation, f/2^17 units
   output logic      [2:0]              msk_fraction_out,  // MSK phase-change fraction
   output txm_radio_state_t             next_state_out,    // State after packet
   output logic                         next_state_valid_out // One-cycle pulse
);

   // Register storage
   logic [7:0] mod_upper;
   logic [7:0] spc_mant;
   logic [7:0] deviation;
   logic [7:0] state_cfg;
   logic [7:0] next_mod_upper;
   logic [7:0] next_spc_mant;
   logic [7:0] next_deviation;
   logic [7:0] next_state_cfg;
   logic [7:0] next_rdata;

   // Derived words
   txm_cfg_t               cfg;
   logic [4:0]             next_preamble;
   logic [TXM_SPC_W-1:0]   next_spacing;
   logic [BASE_W:0]        next_carrier;
   logic [TXM_DEV_W-1:0]   next_dev;
   logic [2:0]             next_fraction;
   logic                   next_fec;
   txm_radio_state_t       next_after;
   logic                   next_after_valid;

   // Widened mantissas with their implicit leading ones
   logic [TXM_SPC_W-1:0]   spc_base;
   logic [TXM_DEV_W-1:0]   dev_base;

   // Register writes and reads. Reserved bits are masked on the way in, so a
   // read never has to mask again. A read and a write in the same cycle see the
   // old contents, which suits a host that reads before it overwrites.
   // Writes to unmapped offsets fall through every branch and change nothing.
   // Read data is registered and holds until the next read strobe.
   always_comb begin
      next_mod_upper = mod_upper;
      next_spc_mant  = spc_mant;
      next_deviation = deviation;
      next_state_cfg = state_cfg;
      next_rdata     = reg_rdata_out;
      // Only the writable bits of each byte are stored
      if (reg_wr_in) begin
         if (reg_addr_in == TXM_ADDR_MOD_UPPER) begin
            next_mod_upper = reg_wdata_in & TXM_MASK_MOD_UPPER;
         end else if (reg_addr_in == TXM_ADDR_SPC_MANT) begin
            next_spc_mant = reg_wdata_in & TXM_MASK_SPC_MANT;
         end else if (reg_addr_in == TXM_ADDR_DEVIATION) begin
            next_deviation = reg_wdata_in & TXM_MASK_DEVIATION;
         end else if (reg_addr_in == TXM_ADDR_STATE_CFG) begin
            next_state_cfg = reg_wdata_in & TXM_MASK_STATE_CFG;
         end
      end
      // Unmapped offsets read as zero rather than echoing stale data
      if (reg_rd_in) begin
         if (reg_addr_in == TXM_ADDR_MOD_UPPER) begin
            next_rdata = mod_upper;
         end else if (reg_addr_in == TXM_ADDR_SPC_MANT) begin
            next_rdata = spc_mant;
         end else if (reg_addr_in == TXM_ADDR_DEVIATION) begin
            next_rdata = deviation;
         end else if (reg_addr_in == TXM_ADDR_STATE_CFG) begin
            next_rdata = state_cfg;
         end else begin
            next_rdata = TXM_READ_ZERO;                           // Unmapped reads zero
         end
      end
   end

   // Register bank and read data; reset loads the power-on defaults
   // Only constants appear in the reset branch, so reset never races a write
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mod_upper     <= TXM_RST_MOD_UPPER;
         spc_mant      <= TXM_RST_SPC_MANT;
         deviation     <= TXM_RST_DEVIATION;
         state_cfg     <= TXM_RST_STATE_CFG;
         reg_rdata_out <= TXM_READ_ZERO;
      end else begin
         mod_upper     <= next_mod_upper;
         spc_mant      <= next_spc_mant;
         deviation     <= next_deviation;
         state_cfg     <= next_state_cfg;
         reg_rdata_out <= next_rdata;
      end
   end

   // Field extraction: each field is a fixed slice of its register, so the
   // derived words below never see the reserved positions
   assign cfg.error_correction_enable = mod_upper[TXM_FEC_BIT];
   assign cfg.preamble_code           = mod_upper[TXM_PRE_LSB +: 3];
   assign cfg.spacing_exponent        = mod_upper[TXM_SPC_E_LSB +: 2];
   assign cfg.spacing_mantissa        = spc_mant;
   assign cfg.deviation_exponent      = deviation[TXM_DEV_E_LSB +: 3];
   assign cfg.deviation_mantissa      = deviation[TXM_DEV_M_LSB +: 3];
   assign cfg.tx_completion_state     = state_cfg[TXM_TXOFF_LSB +: 2];

   // Derived modulator words, computed from the stored fields (the carrier from the base, channel and spacing word) and then
   // registered. Exponents are plain left shifts, so every word is exact and
   // no rounding is ever applied.
   always_comb begin
      next_fec = cfg.error_correction_enable;
      case (cfg.preamble_code)
         3'h0: next_preamble = TXM_PRE_BYTES_0;
         3'h1: next_preamble = TXM_PRE_BYTES_1;
         3'h2: next_preamble = TXM_PRE_BYTES_2;
         3'h3: next_preamble = TXM_PRE_BYTES_3;
         3'h4: next_preamble = TXM_PRE_BYTES_4;
         3'h5: next_preamble = TXM_PRE_BYTES_5;
         3'h6: next_preamble = TXM_PRE_BYTES_6;
         default: next_preamble = TXM_PRE_BYTES_7;                            // Code 7, longest preamble
      endcase

      // Implicit one above the stored mantissa, widened before the shift so the
      // top bits of the widest spacing are kept
      spc_base     = TXM_SPC_W'(TXM_SPC_IMPLICIT | {1'b0, cfg.spacing_mantissa});
      next_spacing = spc_base << cfg.spacing_exponent;

      // Product formed at full carrier width; the registered spacing word keeps the
      // multiplier operand settled, at the cost of one more cycle of lag
      next_carrier = (BASE_W+1)'(base_freq_in)
                   + ((BASE_W+1)'(channel_index_in) * (BASE_W+1)'(spacing_word_out));

      // Deviation mantissa also carries an implicit one; in MSK the same bits are
      // a phase-change fraction, so the deviation word is parked at zero
      dev_base = TXM_DEV_W'(TXM_DEV_IMPLICIT | {1'b0, cfg.deviation_mantissa});
      if (msk_mode_in) begin
         next_dev      = '0;
         next_fraction = cfg.deviation_mantissa;
      end else begin
         next_dev      = dev_base << cfg.deviation_exponent;
         next_fraction = '0;
      end
   end

   // Completion-state selection on packet end. Code 11 asks for a receive state
   // that this transmitter lacks; should a host write it anyway, fall back to idle.
   always_comb begin
      next_after_valid = packet_done_in;
      next_after       = next_state_out;                                      // Held between packets
      if (packet_done_in) begin
         case (cfg.tx_completion_state)
            2'b00:   next_after = TXM_ST_IDLE;
            2'b01:   next_after = TXM_ST_SYNTH_ON;
            2'b10:   next_after = TXM_ST_TX;
            default: next_after = TXM_ST_IDLE;
         endcase
      end
   end

   // Output registers: every derived word and the completion pulse leave
   // from flip-flops, so the controller never sees a combinational glitch
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fec_enable_out       <= 1'b0;
         preamble_bytes_out   <= TXM_PRE_BYTES_0;
         spacing_word_out     <= '0;
         carrier_word_out     <= '0;
         deviation_word_out   <= '0;
         msk_fraction_out     <= '0;
         next_state_out       <= TXM_ST_IDLE;
         next_state_valid_out <= 1'b0;
      end else begin
         fec_enable_out       <= next_fec;
         preamble_bytes_out   <= next_preamble;
         spacing_word_out     <= next_spacing;
         carrier_word_out     <= next_carrier;
         deviation_word_out   <= next_dev;
         msk_fraction_out     <= next_fraction;
         next_state_out       <= next_after;
         next_state_valid_out <= next_after_valid;
      end
   end

endmodule

// [verif/txm_config_asserts.sv]
// Checker for the modulator configuration bank: readback, derived words, completion.
// Assumes it is bound to txm_config and sees only that module's ports.
`timescale 1ns/1ps
module txm_config_asserts
   import txm_pkg::*;
#(
   parameter int BASE_W = 26,                        // Base word width
   parameter int CHANNEL_INDEX_W = 8                          // Channel width
) (
   input wire logic                 sys_clk_in,      // Clock
   input wire logic                 resetn_in,       // Reset, low
   input wire logic [5:0]           reg_addr_in,     // Address
   input wire logic                 reg_wr_in,       // Write strobe
   input wire logic                 reg_rd_in,       // Read strobe
   input wire logic [7:0]           reg_wdata_in,    // Write data
   input wire logic [7:0]           reg_rdata_out,   // Read data
   input wire logic [BASE_W-1:0]    base_freq_in,    // Base word
   input wire logic [CHANNEL_INDEX_W-1:0]    channel_index_in,// Channel
   input wire logic                 msk_mode_in,     // MSK select
   input wire logic                 packet_done_in,  // Packet sent
   input wire logic                 fec_enable_out,  // Coding on
   input wire logic [4:0]           preamble_bytes_out, // Preamble bytes
   input wire logic [TXM_SPC_W-1:0] spacing_word_out,// Spacing
   input wire logic [BASE_W:0]      carrier_word_out,// Carrier
   input wire logic [TXM_DEV_W-1:0] deviation_word_out, // Deviation
   input wire logic [2:0]           msk_fraction_out,// MSK fraction
   input txm_radio_state_t          next_state_out,  // Next state
   input wire logic                 next_state_valid_out // State pulse
);
   localparam logic [4:0] PB [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
   logic [1:0]           warm;                       // Edges since reset
   logic [7:0]           m13, m14, m15, m17;         // Shadow registers
   logic [7:0]           rd_now;                     // Expected read data
   logic [TXM_SPC_W-1:0] spc;                        // Expected spacing
   logic [TXM_DEV_W-1:0] dev;                        // Expected deviation
   // Shadow of each register as masked on write
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {warm, m13, m14, m15, m17} <= {2'h0, TXM_RST_MOD_UPPER, TXM_RST_SPC_MANT, TXM_RST_DEVIATION, 8'h00};
      end else begin
         warm <= (warm == 2'h3) ? warm : warm + 2'h1;
         if (reg_wr_in && reg_addr_in == TXM_ADDR_MOD_UPPER) m13 <= reg_wdata_in & TXM_MASK_MOD_UPPER;
         if (reg_wr_in && reg_addr_in == TXM_ADDR_SPC_MANT) m14 <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == TXM_ADDR_DEVIATION) m15 <= reg_wdata_in & TXM_MASK_DEVIATION;
         if (reg_wr_in && reg_addr_in == TXM_ADDR_STATE_CFG) m17 <= reg_wdata_in & TXM_MASK_STATE_CFG;
      end
   end
   // Expected values from the shadows
   assign rd_now = reg_addr_in == TXM_ADDR_MOD_UPPER ? m13 : reg_addr_in == TXM_ADDR_SPC_MANT ? m14 :
                   reg_addr_in == TXM_ADDR_DEVIATION ? m15 : reg_addr_in == TXM_ADDR_STATE_CFG ? m17 : 8'h00;
   assign spc = TXM_SPC_W'({1'b1, m14}) << m13[1:0];
   assign dev = TXM_DEV_W'({1'b1, m15[2:0]}) << m15[6:4];
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in || warm != 2'h3);
   read_back_a: assert property (reg_rd_in |=> reg_rdata_out == $past(rd_now))
      else $error("read data wrong");
   rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
   fec_out_a: assert property (fec_enable_out == $past(m13[7])) else $error("fec enable wrong");
   preamble_map_a: assert property (preamble_bytes_out == PB[$past(m13[6:4])])
      else $error("preamble wrong");
   spacing_word_a: assert property (spacing_word_out == $past(spc))
      else $error("spacing wrong");
   carrier_sum_a: assert property (carrier_word_out == $past(base_freq_in) + $past(channel_index_in)
      * $past(spacing_word_out)) else $error("carrier wrong");
   fsk_dev_a: assert property (deviation_word_out == ($past(msk_mode_in) ? 11'h000 : $past(dev)))
      else $error("deviation wrong");
   msk_frac_a: assert property (msk_fraction_out == ($past(msk_mode_in) ? $past(m15[2:0]) : 3'h0))
      else $error("msk fraction wrong");
   done_state_a: assert property (packet_done_in |=> next_state_valid_out && 2'(next_state_out) ==
      ($past(m17[1:0]) == 2'h3 ? 2'h0 : $past(m17[1:0]))) else $error("next state wrong");
   valid_cause_a: assert property (next_state_valid_out |-> $past(packet_done_in))
      else $error("stray pulse");
   state_hold_a: assert property (!packet_done_in |=> $stable(next_state_out)) else $error("state moved");
   cover property (packet_done_in && m17[1:0] == 2'h2);
   cover property (reg_wr_in && reg_addr_in == TXM_ADDR_SPC_MANT);
   cover property (msk_mode_in && m15[2:0] == 3'h6);
endmodule
bind txm_config txm_config_asserts #(.BASE_W(BASE_W), .CHANNEL_INDEX_W(CHANNEL_INDEX_W)) chk_i (.sys_clk_in(sys_clk_in),
   .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .base_freq_in(base_freq_in),
   .channel_index_in(channel_index_in), .msk_mode_in(msk_mode_in), .packet_done_in(packet_done_in),
   .fec_enable_out(fec_enable_out), .preamble_bytes_out(preamble_bytes_out), .spacing_word_out(spacing_word_out),
   .carrier_word_out(carrier_word_out), .deviation_word_out(deviation_word_out),
   .msk_fraction_out(msk_fraction_out), .next_state_out(next_state_out),
   .next_state_valid_out(next_state_valid_out));

// [verif/txm_config_tb.sv]
// Self-checking bench for the modulator configuration bank.
// Assumes the package and the bound checker are compiled before it.
`timescale 1ns/1ps
module txm_config_tb
   import txm_pkg::*;
;
   localparam logic [4:0] PB [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
   logic clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, msk = 1'b0, pd = 1'b0, fec, vld;
   logic [5:0]  addr = 6'h00;
   logic [7:0]  wdata = 8'h00, rdata;
   logic [25:0] base = 26'h0001234;
   logic [7:0]  channel_index = 8'h00;
   logic [4:0]  pre;
   logic [11:0] spc;
   logic [26:0] car;
   logic [10:0] dev;
   logic [2:0]  frac;
   txm_radio_state_t nst;
   int num_errors = 0;
   int tests_run = 0;
   txm_config dut (.sys_clk_in(clk), .resetn_in(resetn), .reg_addr_in(addr), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .base_freq_in(base), .channel_index_in(channel_index),
      .msk_mode_in(msk), .packet_done_in(pd), .fec_enable_out(fec), .preamble_bytes_out(pre),
      .spacing_word_out(spc), .carrier_word_out(car), .deviation_word_out(dev), .msk_fraction_out(frac),
      .next_state_out(nst), .next_state_valid_out(vld));
   // Clock, 20 ns period
   always #10 clk = ~clk;
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // One-cycle register strobes, entered just after an edge, then one idle
   // cycle so a following call never raises a strobe in the step it fell
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(posedge clk);
      #1 wr_s = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      addr = a;
      rd_s = 1'b1;
      @(posedge clk);
      #1 rd_s = 1'b0;
      chk(32'(rdata), 32'(e));
      @(posedge clk);
      #1;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Reset values and unmapped read
   task automatic t_reset();
      rd(6'h13, 8'h22);
      rd(6'h14, 8'hF8);
      rd(6'h15, 8'h47);
      rd(6'h17, 8'h00);
      rd(6'h16, 8'h00);
      chk(32'(spc), (32'd256 + 32'd248) << 2);
      chk(32'(dev), (32'd8 + 32'd7) << 4);
   endtask
   // All ones written, FE to state config: reserved bits stay zero, unmapped write ignored
   task automatic t_reserved();
      wr(6'h13, 8'hFF);
      wr(6'h14, 8'hFF);
      wr(6'h15, 8'hFF);
      wr(6'h17, 8'hFE);
      wr(6'h16, 8'hFF);
      rd(6'h13, 8'hF3);
      rd(6'h14, 8'hFF);
      rd(6'h15, 8'h77);
      rd(6'h17, 8'h02);
      rd(6'h16, 8'h00);
   endtask
   // Every preamble code with alternating error-correction enable
   task automatic t_preamble();
      for (int c = 0; c < 8; c++) begin
         wr(6'h13, {c[0], 3'(c), 4'h0});
         settle();
         chk(32'(pre), 32'(PB[c]));
         chk(32'(fec), 32'(c[0]));
      end
   endtask
   // Spacing exponents 3 down to 1 with mantissas 00, 7F and FE, carrier from channel
   task automatic t_spacing();
      for (int i = 0; i < 3; i++) begin
         channel_index = 8'(8'hFF - 8'(i * 100));
         wr(6'h13, 8'(3 - i));
         wr(6'h14, 8'(i * 8'h7F));
         settle();
         chk(32'(spc), (32'd256 + 32'(i * 8'h7F)) << (3 - i));
         chk(32'(car), 32'(base) + 32'(channel_index) * ((32'd256 + 32'(i * 8'h7F)) << (3 - i)));
      end
   endtask
   // Deviation fields read as FSK words, then as MSK fraction
   task automatic t_deviation();
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 3; i++) begin
            msk = k[0];
            wr(6'h15, {1'b0, 3'(7 - 3 * i), 1'b0, 3'(3 * i)});
            settle();
            chk(32'(dev), k ? 32'h0 : (32'd8 + 32'(3 * i)) << (7 - 3 * i));
            chk(32'(frac), k ? 32'(3 * i) : 32'h0);
         end
      end
   endtask
   // Each completion code the host may use, then pulse ends
   task automatic t_done();
      for (int c = 0; c < 3; c++) begin
         wr(6'h17, 8'(c));
         pd = 1'b1;
         @(posedge clk);
         #1 pd = 1'b0;
         chk(32'(vld), 32'h1);
         chk(32'(nst), 32'(c));
         @(posedge clk);
         #1 chk(32'(vld), 32'h0);
      end
   endtask
   // Watchdog against a hang
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
   // Reset, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      t_reset();
      t_reserved();
      t_preamble();
      t_spacing();
      t_deviation();
      t_done();
      final_report();
   end
endmodule
